// ---- core/b3v_cfg.svh ----
// constants for the third step-down converter control register
// assumes an 8-bit subaddressed register port and a 25 MHz system clock
`ifndef B3V_CFG_SVH
`define B3V_CFG_SVH

`define B3V_SUBADDR 8'h18
`define B3V_RESET_VAL 8'h1F
`define B3V_PSKIP_RST 1'b1
`define B3V_PSKIP_BIT 7
`define B3V_RSVD_BIT 6
`define B3V_CODE_MSB 5
`define B3V_CODE_LSB 0
`define B3V_CLK_HZ 25000000
`define B3V_BLANK_MS 5
`define B3V_BLANK_CYC ((`B3V_CLK_HZ / 1000) * `B3V_BLANK_MS)

`endif

// ---- core/b3v_pkg.sv ----
// types for the third step-down converter control register
// assumes b3v_cfg.svh provides the numeric constants
package b3v_pkg;

  // one register access from the serial register interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } b3v_req_t;

  // converter controls handed to the power stage
  typedef struct packed {
    logic pulse_skip_enable;
    logic [5:0] buck3_voltage_code;
  } b3v_ctrl_t;

  typedef enum logic [1:0] {
    B3V_LOAD_DEFAULT,
    B3V_RUN
  } b3v_state_t;

endpackage

// ---- core/b3v_blank_timer.sv ----
// blanking interval timer for the converter voltage monitors
// assumes start is a one-cycle pulse in the system clock domain
`timescale 1ns/1ps
module b3v_blank_timer #(
  parameter int unsigned CYCLES = 125000
) (
  input wire logic i_clk,   // system clock
  input wire logic i_srst,  // synchronous reset, active high
  input wire logic i_ce,    // clock enable
  input wire logic i_start, // restart the interval
  output logic o_active     // interval running
);

  localparam int unsigned W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;

  initial begin
    if (CYCLES < 1) begin
      $error("blank timer needs at least one cycle");
    end
  end

  // a new write restarts the full interval, so monitoring stays quiet after the last one
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= '0;
      o_active <= 1'b0;
    end else if (i_ce) begin
      if (i_start) begin
        cnt_r <= W'(CYCLES - 1);
        o_active <= 1'b1;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - W'(1);
      end else begin
        o_active <= 1'b0;
      end
    end
  end

endmodule

// ---- core/b3v_reg.sv ----
// third step-down converter control register: voltage code and pulse-skip mode
// assumes single-cycle register strobes from the serial interface decoder,
// an unlock flag from the password logic and a level from the default resistor
`timescale 1ns/1ps
`include "b3v_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module b3v_reg #(
  parameter int unsigned BLANK_CYCLES = `B3V_BLANK_CYC
) (
  input wire logic I_SYS_CLK,               // system clock, 25 MHz
  input wire logic I_SRST,                  // synchronous reset, active high
  input wire logic I_CE,                    // clock enable, freezes all state
  input wire b3v_pkg::b3v_req_t I_REQ,      // register access strobe
  input wire logic I_UNLOCKED,              // password unlock completed
  input wire logic I_DEFAULT_LOAD,          // pulse: apply resistor default
  input wire logic [5:0] I_DEFAULT_CODE,    // code chosen by default resistor
  input wire logic I_UV_FAULT_RAW,          // raw under-voltage detect
  input wire logic I_OV_FAULT_RAW,          // raw over-voltage detect
  output logic [7:0] O_RDATA,               // read data
  output logic O_RVALID,                    // read data valid, one cycle
  output logic O_WR_ACCEPTED,               // write taken, one cycle
  output b3v_pkg::b3v_ctrl_t O_CTRL,        // converter controls
  output logic O_BLANKING,                  // monitors blanked
  output logic O_UV_FAULT,                  // qualified under-voltage fault
  output logic O_OV_FAULT                   // qualified over-voltage fault
);
  import b3v_pkg::*;

  initial begin
    // a zero interval would leave only the write cycle itself masked
    if (BLANK_CYCLES < 1) begin
      $error("blanking needs at least one cycle");
    end
    // the field functions assume a six-bit code below the reserved and mode bits
    if (`B3V_CODE_MSB - `B3V_CODE_LSB != 5) begin
      $error("voltage code field must be six bits wide");
    end
    if (`B3V_PSKIP_BIT <= `B3V_RSVD_BIT || `B3V_RSVD_BIT <= `B3V_CODE_MSB) begin
      $error("field positions out of order");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic hit(input b3v_req_t r);
    return r.addr == `B3V_SUBADDR;
  endfunction

  // pulse-skip field of a write word
  function automatic logic wr_pskip(input logic [7:0] w);
    return w[`B3V_PSKIP_BIT];
  endfunction

  // voltage code field of a write word; the reserved bit is dropped here
  function automatic logic [5:0] wr_code(input logic [7:0] w);
    return w[`B3V_CODE_MSB:`B3V_CODE_LSB];
  endfunction

  // read word as the host sees it, reserved bit forced low
  function automatic logic [7:0] rd_word(input logic p, input logic [5:0] c);
    logic [7:0] w;
    w = 8'h00;
    w[`B3V_PSKIP_BIT] = p;
    w[`B3V_RSVD_BIT] = 1'b0;
    w[`B3V_CODE_MSB:`B3V_CODE_LSB] = c;
    return w;
  endfunction

  logic wr_hit;
  logic rd_hit;
  logic wr_ok;
  // a locked write leaves no trace: no field change, no accept pulse, no blanking
  assign wr_hit = I_REQ.wr && hit(I_REQ);
  assign rd_hit = I_REQ.rd && hit(I_REQ);
  assign wr_ok = wr_hit && I_UNLOCKED;

  //////////////////////////////////////////////////////////////////////////////
  // register fields

  // state remembers whether the resistor default may still be applied
  logic pskip_r;
  logic [5:0] code_r;
  b3v_state_t state_r;

  // resistor default replaces the nominal code once, after reset
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      state_r <= B3V_LOAD_DEFAULT;
    end else if (I_CE) begin
      unique case (state_r)
        B3V_LOAD_DEFAULT: begin
          if (wr_ok || I_DEFAULT_LOAD) begin
            state_r <= B3V_RUN;
          end
        end
        B3V_RUN: begin
          state_r <= B3V_RUN;
        end
      endcase
    end
  end

  // mode bit: 0 forces fixed-frequency switching, 1 lets light load skip pulses
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      pskip_r <= `B3V_PSKIP_RST;
    end else if (I_CE) begin
      if (wr_ok) begin
        pskip_r <= wr_pskip(I_REQ.wdata);
      end
    end
  end

  // a write in the same cycle as the default pulse wins: the host asked for it last
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      code_r <= 6'(`B3V_RESET_VAL);
    end else if (I_CE) begin
      if (wr_ok) begin
        code_r <= wr_code(I_REQ.wdata);
      end else if (I_DEFAULT_LOAD && state_r == B3V_LOAD_DEFAULT) begin
        code_r <= I_DEFAULT_CODE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path and outputs

  // accept and valid pulses stand for exactly one enabled cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_RVALID <= 1'b0;
    end else if (I_CE) begin
      O_RVALID <= rd_hit;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_WR_ACCEPTED <= 1'b0;
    end else if (I_CE) begin
      O_WR_ACCEPTED <= wr_ok;
    end
  end

  // read data holds the last read word, so a slow host may fetch it late
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_RDATA <= 8'h00;
    end else if (I_CE) begin
      if (rd_hit) begin
        O_RDATA <= rd_word(pskip_r, code_r);
      end
    end
  end

  // the power stage sees one registered word, one cycle behind the fields
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_CTRL <= '0;
    end else if (I_CE) begin
      O_CTRL <= '{pulse_skip_enable: pskip_r, buck3_voltage_code: code_r};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // monitor blanking

  logic blank_active;
  // the timer restarts on every accepted write, so the last write sets the end

  b3v_blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) u_blank (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_start(wr_ok),
    .o_active(blank_active)
  );

  // faults are masked in the write cycle too, before the timer output rises
  logic mask_now;
  assign mask_now = blank_active || wr_ok;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_BLANKING <= 1'b0;
    end else if (I_CE) begin
      O_BLANKING <= mask_now;
    end
  end

  // a fault still present when blanking ends shows on the next edge
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_UV_FAULT <= 1'b0;
    end else if (I_CE) begin
      O_UV_FAULT <= I_UV_FAULT_RAW && !mask_now;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_OV_FAULT <= 1'b0;
    end else if (I_CE) begin
      O_OV_FAULT <= I_OV_FAULT_RAW && !mask_now;
    end
  end

endmodule

// ---- sim/b3v_checker.sv ----
// port checker for the buck3 control register
// assumes I_CE held high and BLANK_CYCLES of 8 or more
`timescale 1ns/1ps
module b3v_checker (
  input wire logic I_SYS_CLK, // clock
  input wire logic I_SRST, // reset
  input wire b3v_pkg::b3v_req_t I_REQ, // request
  input wire logic I_UNLOCKED, // unlock
  input wire logic [7:0] O_RDATA, // read data
  input wire logic O_RVALID, // read valid
  input wire logic O_WR_ACCEPTED, // write taken
  input wire b3v_pkg::b3v_ctrl_t O_CTRL, // controls
  input wire logic O_BLANKING, // blanking
  input wire logic O_UV_FAULT, // uv
  input wire logic O_OV_FAULT // ov
);
  import b3v_pkg::*;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  wire hit = I_REQ.addr == 8'h18;
  sequence s_wr; I_REQ.wr && hit && I_UNLOCKED; endsequence
  sequence s_blank; O_BLANKING [*8]; endsequence
  property p_wr; s_wr |=> O_WR_ACCEPTED; endproperty
  property p_lock; I_REQ.wr && !(hit && I_UNLOCKED) |=> !O_WR_ACCEPTED; endproperty
  property p_rd; I_REQ.rd && hit |=> O_RVALID; endproperty
  property p_miss; I_REQ.rd && !hit |=> !O_RVALID; endproperty
  property p_rsv; O_RVALID |-> !O_RDATA[6]; endproperty
  property p_blk; s_wr |=> s_blank; endproperty
  property p_mask; O_BLANKING |-> !(O_UV_FAULT || O_OV_FAULT); endproperty
  property p_ctrl;
    s_wr |-> ##2 O_CTRL == {$past(I_REQ.wdata[7], 2), $past(I_REQ.wdata[5:0], 2)};
  endproperty
  a_wr: assert property (p_wr) else $error("write not taken");
  a_lock: assert property (p_lock) else $error("locked write taken");
  a_rd: assert property (p_rd) else $error("read not answered");
  a_miss: assert property (p_miss) else $error("foreign read answered");
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  a_blk: assert property (p_blk) else $error("blanking short");
  a_mask: assert property (p_mask) else $error("fault while blanked");
  a_ctrl: assert property (p_ctrl) else $error("controls wrong");
endmodule
bind b3v_reg b3v_checker chk (.I_SYS_CLK, .I_SRST, .I_REQ, .I_UNLOCKED, .O_RDATA,
  .O_RVALID, .O_WR_ACCEPTED, .O_CTRL, .O_BLANKING, .O_UV_FAULT, .O_OV_FAULT);

// ---- sim/b3v_host.sv ----
// host model issuing one-cycle register requests
// assumes the register samples on the next rising edge
`timescale 1ns/1ps
module b3v_host (
  input wire logic i_clk, // clock
  output b3v_pkg::b3v_req_t o_req, // request
  output logic o_unlocked // unlock level
);
  import b3v_pkg::*;
  initial begin
    o_req = '0;
    o_unlocked = 1'b0;
  end
  // unlock lasts one access only, so each write carries its own
  task automatic acc(input logic w, r, input logic [7:0] a, d, input logic u);
    @(posedge i_clk);
    o_req <= {w, r, a, d};
    o_unlocked <= u;
    @(posedge i_clk);
    o_req <= {2'b00, ~a, ~d};
    o_unlocked <= 1'b0;
  endtask
endmodule

// ---- sim/test_buck3_voltage_control_reg.sv ----
// testbench for the buck3 control register
// assumes b3v_host drives the request port
`timescale 1ns/1ps
module test_buck3_voltage_control_reg;
  import b3v_pkg::*;
  logic clk = 0, srst = 1, ce = 1, dl = 0, uv = 0, ov = 0, rv, wa, blk, uvf, ovf, unl, hit;
  logic [5:0] dc = '0;
  logic [7:0] rd, d, a;
  b3v_req_t req;
  b3v_ctrl_t ctrl;
  logic [7:0] tbl [3] = '{8'h40, 8'hff, 8'h3f};
  int fail_count = 0, samples_checked = 0, cyc = 0, ps = 1, cd = 'h1f;
  always #20 clk = ~clk;
  b3v_host host (.i_clk(clk), .o_req(req), .o_unlocked(unl));
  b3v_reg #(.BLANK_CYCLES(20)) dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_CE(ce),
    .I_REQ(req), .I_UNLOCKED(unl), .I_DEFAULT_LOAD(dl), .I_DEFAULT_CODE(dc),
    .I_UV_FAULT_RAW(uv), .I_OV_FAULT_RAW(ov), .O_RDATA(rd), .O_RVALID(rv),
    .O_WR_ACCEPTED(wa), .O_CTRL(ctrl), .O_BLANKING(blk), .O_UV_FAULT(uvf), .O_OV_FAULT(ovf));
  task chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task rdchk(input logic [7:0] ad);
    host.acc(0, 1, ad, 8'h00, 0);
    #1 chk({7'b0, rv}, {7'b0, ad == 8'h18});
    if (ad == 8'h18) chk(rd, {ps[0], 1'b0, cd[5:0]});
    chk({1'b0, ctrl}, {1'b0, ps[0], cd[5:0]});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    d = $urandom(32'h4034_9249);
    repeat (2) @(posedge clk);
    srst <= 0;
    repeat (3) @(posedge clk);
    #1 chk({1'b0, ctrl}, 8'h5f);
    // only the first default pulse after reset counts
    for (int i = 0; i < 2; i++) begin
      d = $urandom;
      @(posedge clk);
      dl <= 1;
      dc <= d[5:0];
      if (i == 0) cd = d[5:0];
      @(posedge clk);
      dl <= 0;
    end
    rdchk(8'h18);
    for (int i = 0; i < 10; i++) begin
      d = (i < 3) ? tbl[i] : 8'($urandom);
      a = (i % 4 == 3) ? 8'h19 : 8'h18;
      hit = a == 8'h18 && i % 5 != 4;
      host.acc(1, 0, a, d, i % 5 != 4);
      uv <= 1'($urandom);
      ov <= 1'($urandom);
      if (hit) ps = d[7];
      if (hit) cd = d[5:0];
      #1 chk({7'b0, wa}, {7'b0, hit});
      if (hit) chk({7'b0, blk}, 8'h01);
      if (hit) chk({6'b0, uvf, ovf}, 8'h00);
      @(posedge clk);
      rdchk(a);
    end
    @(posedge clk);
    uv <= 0;
    ov <= 0;
    repeat (25) @(posedge clk);
    // clock enable low freezes the fault outputs even with both detectors raised
    ce <= 0;
    uv <= 1;
    ov <= 1;
    repeat (2) @(posedge clk);
    #1 chk({6'b0, uvf, ovf}, 8'h00);
    chk({1'b0, ctrl}, {1'b0, ps[0], cd[5:0]});
    @(posedge clk);
    ce <= 1;
    repeat (2) @(posedge clk);
    #1 chk({6'b0, uvf, ovf}, 8'h03);
    wrap_up;
  end
endmodule
